// ===== rtl/cmpc_top.sv
// contact monitor pin control: serial link, switch debounce, interrupt, watchdog, reset
`timescale 1ns/10ps
`default_nettype none
module cmpc_top #(
	parameter int DEB_CYC = cmpc_pkg::CMPC_DEB_CYC,
	parameter int WD1_CYC = cmpc_pkg::CMPC_WD1_CYC,
	parameter int WD2_CYC = cmpc_pkg::CMPC_WD2_CYC,
	parameter int RST_CYC = cmpc_pkg::CMPC_RST_CYC
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic [7:0] i_switch_inputs,
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_sdi,
	input wire logic i_watchdog_kick,
	input wire logic i_shutdown_n,
	input wire logic i_regulator_on_n,
	input wire logic i_regulator_hold_n,
	input wire logic i_thermal_warn,
	input wire logic i_regulator_low,
	output logic o_sdo,
	output logic o_sdo_oe_n,
	output logic o_int_n_o,
	output logic o_int_n_oe_n,
	output logic o_overtemp_warn_n_o,
	output logic o_overtemp_warn_n_oe_n,
	output logic o_rst_n_o,
	output logic o_rst_n_oe_n,
	output logic o_direct_out_ch0,
	output logic o_direct_out_ch1,
	output logic o_regulator_en,
	output logic [15:0] o_command
);
	localparam int W = cmpc_pkg::CMPC_CNT_W;
	// two-flop synchronisers for every outside input except i_nrst
	// reset to idle levels: controls and chip select high, link clock low, no false edge
	logic [8:0] s1_q;
	logic [8:0] s2_q;
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			s1_q <= 9'h1e0;
			s2_q <= 9'h1e0;
		end else begin
			s1_q <= {i_regulator_hold_n, i_regulator_on_n, i_shutdown_n, i_cs_n, i_sclk,
				i_sdi, i_watchdog_kick, i_thermal_warn, i_regulator_low};
			s2_q <= s1_q;
		end
	end
	logic [7:0] sw_s1_q;
	logic [7:0] sw_s2_q;
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			sw_s1_q <= 8'h00;
			sw_s2_q <= 8'h00;
		end else begin
			sw_s1_q <= i_switch_inputs;
			sw_s2_q <= sw_s1_q;
		end
	end
	cmpc_pkg::cmpc_spi_s spi;
	logic hold_n, on_n, sd_n, kick, therm, vlow;
	assign hold_n = s2_q[8];
	assign on_n = s2_q[7];
	assign sd_n = s2_q[6];
	assign spi = '{cs_n: s2_q[5], sclk: s2_q[4], sdi: s2_q[3]};
	assign kick = s2_q[2];
	assign therm = s2_q[1];
	assign vlow = s2_q[0];

	// edge detection of link signals and watchdog kick
	cmpc_pkg::cmpc_spi_s spi_q;
	logic kick_q;
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			spi_q <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
			kick_q <= 1'b0;
		end else begin
			spi_q <= spi;
			kick_q <= kick;
		end
	end
	logic sclk_rise, sclk_fall, cs_rise, cs_fall, kick_edge;
	assign sclk_rise = spi.sclk && !spi_q.sclk && !spi.cs_n;
	assign sclk_fall = !spi.sclk && spi_q.sclk && !spi.cs_n;
	assign cs_rise = spi.cs_n && !spi_q.cs_n;
	assign cs_fall = !spi.cs_n && spi_q.cs_n;
	assign kick_edge = kick ^ kick_q;

	// debounce per channel
	logic [7:0] deb_q;
	logic [W-1:0] deb_cnt_q [8];
	logic [7:0] chg_pulse;
	always_ff @(posedge i_mclk) begin
		if (!i_nrst || !sd_n) begin
			deb_q <= 8'h00;
			chg_pulse <= 8'h00;
			for (int i = 0; i < cmpc_pkg::CMPC_N_CH; i++) deb_cnt_q[i] <= '0;
		end else begin
			for (int i = 0; i < cmpc_pkg::CMPC_N_CH; i++) begin
				chg_pulse[i] <= 1'b0;
				if (sw_s2_q[i] == deb_q[i]) begin
					deb_cnt_q[i] <= '0;
				end else if (deb_cnt_q[i] == W'(DEB_CYC - 1)) begin
					deb_q[i] <= sw_s2_q[i];
					chg_pulse[i] <= 1'b1;
					deb_cnt_q[i] <= '0;
				end else begin
					deb_cnt_q[i] <= deb_cnt_q[i] + W'(1);
				end
			end
		end
	end

	// command register and serial shifter
	logic [15:0] cmd_q;
	logic [15:0] sh_in_q;
	logic [15:0] sh_out_q;
	logic direct;
	assign direct = !cmd_q[cmpc_pkg::CMPC_DIRECT_BIT];
	logic [7:0] status;
	assign status = direct ? {deb_q[7:2], 2'b00} : deb_q;
	logic read_done;
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			cmd_q <= cmpc_pkg::CMPC_CMD_RST;
			sh_in_q <= 16'h0000;
			sh_out_q <= 16'h0000;
			o_sdo <= 1'b0;
			o_sdo_oe_n <= 1'b1;
			read_done <= 1'b0;
		end else begin
			read_done <= 1'b0;
			o_sdo_oe_n <= spi.cs_n;
			if (cs_fall) begin
				sh_out_q <= {status, 8'h00};
			end
			if (sclk_fall) begin
				sh_in_q <= {sh_in_q[14:0], spi.sdi};
			end
			if (sclk_rise) begin
				o_sdo <= sh_out_q[15];
				sh_out_q <= {sh_out_q[14:0], 1'b0};
			end
			if (cs_rise) begin
				cmd_q <= sh_in_q;
				read_done <= 1'b1;
			end
		end
	end
	assign o_command = cmd_q;

	// switch-change interrupt pending flag, set beats clear
	logic [7:0] en_chg;
	assign en_chg = chg_pulse & ~cmd_q[7:0] & (direct ? 8'hfc : 8'hff);
	logic sw_irq_q;
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			sw_irq_q <= 1'b0;
		end else if (|en_chg) begin
			sw_irq_q <= 1'b1;
		end else if (read_done) begin
			sw_irq_q <= 1'b0;
		end
	end

	// watchdog
	cmpc_pkg::cmpc_wd_e wd_q;
	logic [W-1:0] wd_cnt_q;
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			wd_q <= cmpc_pkg::CMPC_WD_RUN;
			wd_cnt_q <= '0;
		end else begin
			case (wd_q)
				cmpc_pkg::CMPC_WD_RUN: begin
					if (kick_edge) begin
						wd_cnt_q <= '0;
					end else if (wd_cnt_q == W'(WD1_CYC - 1)) begin
						wd_q <= cmpc_pkg::CMPC_WD_WARN;
						wd_cnt_q <= '0;
					end else begin
						wd_cnt_q <= wd_cnt_q + W'(1);
					end
				end
				cmpc_pkg::CMPC_WD_WARN: begin
					if (kick_edge) begin
						wd_q <= cmpc_pkg::CMPC_WD_RUN;
						wd_cnt_q <= '0;
					end else if (wd_cnt_q == W'(WD2_CYC - 1)) begin
						wd_q <= cmpc_pkg::CMPC_WD_RST;
						wd_cnt_q <= '0;
					end else begin
						wd_cnt_q <= wd_cnt_q + W'(1);
					end
				end
				cmpc_pkg::CMPC_WD_RST: begin
					if (wd_cnt_q == W'(RST_CYC - 1)) begin
						wd_q <= cmpc_pkg::CMPC_WD_RUN;
						wd_cnt_q <= '0;
					end else begin
						wd_cnt_q <= wd_cnt_q + W'(1);
					end
				end
				default: begin
					wd_q <= cmpc_pkg::CMPC_WD_RUN;
					wd_cnt_q <= '0;
				end
			endcase
		end
	end

	// open-drain outputs, direct channel copies and regulator control
	logic reg_q;
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_int_n_o <= 1'b0;
			o_int_n_oe_n <= 1'b1;
			o_overtemp_warn_n_o <= 1'b0;
			o_overtemp_warn_n_oe_n <= 1'b1;
			o_rst_n_o <= 1'b0;
			o_rst_n_oe_n <= 1'b1;
			o_direct_out_ch0 <= 1'b0;
			o_direct_out_ch1 <= 1'b0;
			reg_q <= 1'b0;
		end else begin
			o_int_n_oe_n <= !(sw_irq_q || wd_q == cmpc_pkg::CMPC_WD_WARN);
			o_overtemp_warn_n_oe_n <= !therm;
			o_rst_n_oe_n <= !(vlow || wd_q == cmpc_pkg::CMPC_WD_RST);
			o_direct_out_ch0 <= direct ? sw_s2_q[0] : 1'b0;
			o_direct_out_ch1 <= direct ? sw_s2_q[1] : 1'b0;
			if (!sd_n) begin
				reg_q <= 1'b0;
			end else if (!on_n) begin
				reg_q <= 1'b1;
			end else if (hold_n) begin
				reg_q <= reg_q;
			end else begin
				reg_q <= 1'b0;
			end
		end
	end
	assign o_regulator_en = reg_q;

	a_sdo_released: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		spi.cs_n |=> o_sdo_oe_n) else $error("sdo driven outside frame");
	a_cmd_commit: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		cs_rise |=> cmd_q == $past(sh_in_q)) else $error("command not committed");
	a_cmd_stable: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		!cs_rise |=> $stable(cmd_q)) else $error("command changed mid frame");
	a_int_on_chg: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		|en_chg |=> ##1 !o_int_n_oe_n) else $error("interrupt not raised");
	a_int_wd: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		wd_q == cmpc_pkg::CMPC_WD_WARN |=> !o_int_n_oe_n) else $error("wd int missing");
	a_ot_follow: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		therm |=> !o_overtemp_warn_n_oe_n) else $error("overtemp not shown");
	a_reg_sd: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		!sd_n |=> !reg_q) else $error("regulator on in shutdown");
	a_reg_on: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		sd_n && !on_n |=> reg_q) else $error("regulator request ignored");
	a_rst_low: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		vlow |=> !o_rst_n_oe_n) else $error("reset not asserted");
	a_kick_restart: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		kick_edge && wd_q != cmpc_pkg::CMPC_WD_RST |=> wd_cnt_q == '0)
		else $error("watchdog not restarted");
	a_mask_block: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		!sw_irq_q && (chg_pulse & ~cmd_q[7:0]) == 8'h00 |=> !sw_irq_q)
		else $error("masked irq raised");
	a_sdo_shift: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		sclk_rise |=> o_sdo == $past(sh_out_q[15])) else $error("sdo not shifted");
	a_sdi_shift: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		sclk_fall |=> sh_in_q[0] == $past(spi.sdi)) else $error("sdi not sampled");
	a_rst_wd: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		wd_q == cmpc_pkg::CMPC_WD_RST |=> !o_rst_n_oe_n) else $error("wd rst missing");
	a_direct_copy: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		direct |=> o_direct_out_ch0 == $past(sw_s2_q[0])) else $error("direct copy");
	a_read_clear: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		read_done && !(|en_chg) |=> !sw_irq_q) else $error("irq not cleared");
	c_write: cover property (@(posedge i_mclk) cs_rise);
	c_wd_warn: cover property (@(posedge i_mclk) wd_q == cmpc_pkg::CMPC_WD_WARN);
	c_sw_irq: cover property (@(posedge i_mclk) |en_chg);
	c_wd_rst: cover property (@(posedge i_mclk) wd_q == cmpc_pkg::CMPC_WD_RST);
	c_read_clear: cover property (@(posedge i_mclk) sw_irq_q && read_done);
endmodule // cmpc_top
`default_nettype wire

// ===== rtl/cmpc_pkg.sv
// package for the contact monitor pin control block
package cmpc_pkg;
	localparam int CMPC_N_CH = 8;
	localparam int CMPC_WORD_W = 16;
	localparam int CMPC_CLK_HZ = 25_000_000;
	// debounce interval in microseconds, watchdog reset pulse in microseconds
	localparam int CMPC_DEB_US = 5_900;
	localparam int CMPC_DEB_CYC = CMPC_DEB_US * (CMPC_CLK_HZ / 1_000_000);
	localparam int CMPC_RST_US = 21_000;
	localparam int CMPC_RST_CYC = CMPC_RST_US * (CMPC_CLK_HZ / 1_000_000);
	localparam int CMPC_WD1_CYC = 4 * CMPC_RST_CYC;
	localparam int CMPC_WD2_CYC = 8 * CMPC_RST_CYC;
	localparam int CMPC_CNT_W = 32;
	// command word fields
	localparam int CMPC_MASK_LSB = 0;
	localparam int CMPC_DIRECT_BIT = 8;
	localparam logic [15:0] CMPC_CMD_RST = 16'h0000;
	typedef enum logic [2:0] {
		CMPC_WD_RUN = 3'b001,
		CMPC_WD_WARN = 3'b010,
		CMPC_WD_RST = 3'b100
	} cmpc_wd_e;
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic sdi;
	} cmpc_spi_s;
endpackage

// ===== bench/cmpc_host.sv
// host model: serial master driving the contact monitor link
`timescale 1ns/10ps
`default_nettype none
module cmpc_host (
	input wire logic i_sdo,
	output var cmpc_pkg::cmpc_spi_s o_spi
);
	initial o_spi = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
	// one whole frame, msb first; status returns on the first 8 bits
	task automatic xfer(input logic [15:0] w, output logic [7:0] st);
		o_spi.cs_n = 1'b0;
		#160;
		for (int i = 15; i >= 0; i--) begin
			o_spi.sclk = 1'b1;
			o_spi.sdi = w[i];
			#160;
			o_spi.sclk = 1'b0;
			#160;
			if (i > 7)
				st[i - 8] = i_sdo;
		end
		#160;
		o_spi.cs_n = 1'b1;
		o_spi.sdi = 1'b0; // released line falls to its pull-down
		#320;
	endtask
endmodule // cmpc_host
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the contact monitor pin control block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk = 1'b0, nrst = 1'b0, kick = 1'b0, kick_on = 1'b0;
	logic sd_n = 1'b1, on_n = 1'b1, hold_n = 1'b0, therm = 1'b0, reglow = 1'b0;
	logic [7:0] sw = 8'h00, st, m_st;
	logic sdo, sdo_oe_n, int_o, int_oe_n, ot_o, ot_oe_n, rst_o, rst_oe_n, d0, d1, reg_en;
	logic [15:0] cmd, w, m_cmd = 16'h0000;
	logic [15:0] exp_cmd [$];
	logic [3:0] rt [4] = '{4'b1001, 4'b1111, 4'b1100, 4'b0010};
	cmpc_pkg::cmpc_spi_s spi;
	wire sdo_pin = sdo_oe_n ? 1'bz : sdo;
	// open-drain pins seen through their pull-ups
	wire int_pin = int_oe_n ? 1'b1 : int_o;
	wire ot_pin = ot_oe_n ? 1'b1 : ot_o;
	wire rst_pin = rst_oe_n ? 1'b1 : rst_o;
	int miscompares = 0, num_checks = 0, cyc = 0, seed;
	always #20 clk = ~clk;
	cmpc_top #(.DEB_CYC(20), .WD1_CYC(80), .WD2_CYC(80), .RST_CYC(20)) uut (
		.i_mclk(clk), .i_nrst(nrst), .i_switch_inputs(sw), .i_cs_n(spi.cs_n),
		.i_sclk(spi.sclk), .i_sdi(spi.sdi), .i_watchdog_kick(kick), .i_shutdown_n(sd_n),
		.i_regulator_on_n(on_n), .i_regulator_hold_n(hold_n), .i_thermal_warn(therm),
		.i_regulator_low(reglow), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_int_n_o(int_o),
		.o_int_n_oe_n(int_oe_n), .o_overtemp_warn_n_o(ot_o), .o_overtemp_warn_n_oe_n(ot_oe_n),
		.o_rst_n_o(rst_o), .o_rst_n_oe_n(rst_oe_n), .o_direct_out_ch0(d0),
		.o_direct_out_ch1(d1), .o_regulator_en(reg_en), .o_command(cmd));
	cmpc_host host (.i_sdo(sdo_pin), .o_spi(spi));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// model: status as the host should read it under the modelled command
	function automatic logic [7:0] m_status(input logic [7:0] lv);
		return m_cmd[8] ? lv : {lv[7:2], 2'b00};
	endfunction
	task automatic host_write(input logic [15:0] wd);
		exp_cmd.push_back(wd);
		host.xfer(wd, st);
		m_cmd = wd;
	endtask
	task automatic conclude();
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(negedge clk) begin
		cyc++;
		if (kick_on && cyc % 8 == 0)
			kick <= ~kick;
		if (cyc == 4000) begin
			miscompares++;
			conclude();
		end
	end
	initial begin
		seed = 32'h9ca7_2b14;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		kick_on = 1'b1;
		chk("sdo_oe_n", 16'h0001, {15'h0, sdo_oe_n});
		chk("command", 16'h0000, cmd);
		chk("rst_pin", 16'h0001, {15'h0, rst_pin});
		repeat (4) begin
			sw = 8'($random(seed));
			repeat (6) @(negedge clk);
			chk("direct", {14'h0, sw[1:0]}, {14'h0, d1, d0});
		end
		repeat (3) begin
			w = 16'($random(seed));
			host_write(w);
			repeat (7) @(negedge clk);
			chk("command", exp_cmd.pop_front(), cmd);
			chk("direct", {14'h0, (m_cmd[8] ? 2'b00 : sw[1:0])}, {14'h0, d1, d0});
		end
		host_write(16'h01f0);
		repeat (40) @(negedge clk);
		chk("command", exp_cmd.pop_front(), cmd);
		m_st = m_status(sw);
		host_write(16'h01f0);
		@(negedge clk);
		chk("status", {8'h0, m_st}, {8'h0, st});
		chk("int_pin", 16'h0001, {15'h0, int_pin});
		chk("direct", 16'h0000, {14'h0, d1, d0});
		chk("command", exp_cmd.pop_front(), cmd);
		sw[5] = ~sw[5];
		repeat (40) @(negedge clk);
		chk("int_pin", 16'h0001, {15'h0, int_pin});
		sw[2] = ~sw[2];
		repeat (10) @(negedge clk);
		chk("int_pin", 16'h0001, {15'h0, int_pin});
		repeat (30) @(negedge clk);
		chk("int_pin", 16'h0000, {15'h0, int_pin});
		host_write(16'h0000);
		repeat (6) @(negedge clk);
		chk("int_pin", 16'h0001, {15'h0, int_pin});
		chk("command", exp_cmd.pop_front(), cmd);
		sw[0] = ~sw[0];
		repeat (40) @(negedge clk);
		chk("int_pin", 16'h0001, {15'h0, int_pin});
		m_st = m_status(sw);
		host_write(16'h0000);
		repeat (6) @(negedge clk);
		chk("status", {8'h0, m_st}, {8'h0, st});
		chk("command", exp_cmd.pop_front(), cmd);
		for (int i = 0; i < 4; i++) begin
			{therm, reglow} = i[1:0];
			repeat (5) @(negedge clk);
			chk("overtemp_pin", {15'h0, !therm}, {15'h0, ot_pin});
			chk("rst_pin", {15'h0, !reglow}, {15'h0, rst_pin});
		end
		for (int i = 0; i < 4; i++) begin
			{sd_n, on_n, hold_n} = rt[i][3:1];
			repeat (6) @(negedge clk);
			chk("regulator_en", {15'h0, rt[i][0]}, {15'h0, reg_en});
		end
		{therm, reglow} = 2'b00;
		kick_on = 1'b0;
		repeat (100) @(negedge clk);
		chk("int_pin", 16'h0000, {15'h0, int_pin});
		chk("rst_pin", 16'h0001, {15'h0, rst_pin});
		repeat (68) @(negedge clk);
		chk("rst_pin", 16'h0000, {15'h0, rst_pin});
		chk("int_pin", 16'h0001, {15'h0, int_pin});
		kick_on = 1'b1;
		repeat (300) @(negedge clk);
		chk("int_pin", 16'h0001, {15'h0, int_pin});
		chk("rst_pin", 16'h0001, {15'h0, rst_pin});
		chk("writes left", 16'h0000, 16'(exp_cmd.size()));
		conclude();
	end
endmodule // tb
`default_nettype wire
